/* ccwp_pkg.sv */
// Constants shared by the cycle counter, supervisory timer and divider
package ccwp_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, low address bits only)
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  ADDR_CFG     = 8'h00;
  localparam logic [7:0]  ADDR_COUNTER = 8'h04;
  localparam logic [7:0]  ADDR_SUPV    = 8'h08;
  localparam logic [7:0]  ADDR_STATUS  = 8'h0c;
  localparam logic [7:0]  ADDR_MASK    = 8'h10;
  localparam logic [7:0]  ADDR_SUPV_CNT = 8'h14;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam int          CFG_SRC_BIT   = 5;
  localparam int          CFG_EDGE_BIT  = 4;
  localparam int          CFG_ASN_BIT   = 3;
  localparam int          CFG_RATIO_LSB = 0;
  localparam int          RATIO_W       = 3;
  localparam logic [7:0]  CFG_MASK      = 8'h3f;
  localparam logic [7:0]  CFG_RST       = 8'h0f;
  localparam int          SUPV_EN_BIT   = 0;
  localparam int          SUPV_KICK_BIT = 1;
  localparam int          STS_SUPV_BIT  = 0;
  localparam logic [7:0]  CNT_MAX       = 8'hff;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;
  localparam logic        HRESP_OKAY    = 1'b0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 5;
  localparam int          SUPV_BASE_NS  = 5000;
  localparam int          SUPV_BASE_CYC = SUPV_BASE_NS / CLK_PERIOD_NS;
  localparam int          WDIV_W        = 16;

endpackage : ccwp_pkg

/* ccwp_div_if.sv */
// Link between the counter logic and the shared divider
`timescale 1ns/1ps
interface ccwp_div_if;
  logic       in_tick;
  logic       clear;
  logic [2:0] ratio;
  logic       out_tick;

  modport owner   (output in_tick, output clear, output ratio, input out_tick);
  modport divider (input in_tick, input clear, input ratio, output out_tick);
endinterface : ccwp_div_if

/* ccwp_divider.sv */
// Shared 8-bit programmable divider, 1:2 to 1:256
`timescale 1ns/1ps
module ccwp_divider
  import ccwp_pkg::*;
#(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Divider link
  ccwp_div_if.divider dv
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } ccwp_div_s;

  ccwp_div_s s_reg;
  ccwp_div_s s_next;

  // ----------------------------------------------------------------
  // Ratio decode
  // ----------------------------------------------------------------
  // Mask of 2^(ratio+1)-1; ratio 7 covers the whole count
  function automatic logic [DIV_W-1:0] ratio_mask(input logic [2:0] r);
    ratio_mask = DIV_W'((2 << r) - 1);
  endfunction : ratio_mask

  // Count input ticks, emit one tick per full ratio period
  always_comb begin
    s_next      = s_reg;
    s_next.tick = 1'b0;
    if (dv.clear) begin
      s_next.cnt = '0;
    end else if (dv.in_tick) begin
      s_next.cnt  = s_reg.cnt + DIV_W'(1);
      s_next.tick = ((s_reg.cnt & ratio_mask(dv.ratio)) == ratio_mask(dv.ratio));
    end
  end

  // State register; count is never visible to software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dv.out_tick = s_reg.tick;

  // Ratio 1:2 fires on every second input tick
  AST_DIV_HALF: assert property (@(posedge hclk) disable iff (!hresetn)
    (dv.in_tick && !dv.clear && dv.ratio == 3'h0 && s_reg.cnt[0]) |=> dv.out_tick)
    else $error("divider missed a 1:2 tick");

endmodule : ccwp_divider

/* ccwp_cycle_event_counter.sv */
// Cycle event counter, supervisory timer and shared divider with AHB-Lite registers
`timescale 1ns/1ps
module ccwp_cycle_event_counter
  import ccwp_pkg::*;
#(
  parameter logic [WDIV_W-1:0] SUPV_BASE = WDIV_W'(SUPV_BASE_CYC)
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // External count pin
  input  wire logic        count_pin,
  // Core interface
  input  wire logic        return_add_work_to_counter,
  input  wire logic [7:0]  work_value,
  output logic             rollover_req,
  output logic             supv_reset_req,
  output logic             irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]        cfg;
    logic [7:0]        cnt;
    logic              pin_prev;
    logic              supv_en;
    logic [7:0]        supv_cnt;
    logic [WDIV_W-1:0] supv_div;
    logic              sts;
    logic              msk;
    logic              ap_pend;
    logic              ap_write;
    logic [ADDR_W-1:0] ap_addr;
    logic [31:0]       rdata;
    logic              ready;
    logic              roll;
    logic              supv_req;
    logic              irq;
    logic              div_clr;
  } ccwp_state_s;

  localparam ccwp_state_s ST_RST = '{cfg: CFG_RST, ready: 1'b1, default: '0};

  ccwp_state_s s_reg;
  ccwp_state_s s_next;
  ccwp_div_if  dv ();

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Address match for the pending data phase
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  logic       take;
  logic       wr;
  logic       wr_cfg;
  logic       wr_cnt;
  logic       wr_supv;
  logic       kick;
  logic       ext_edge;
  logic       src_tick;
  logic       inc;
  logic       base_tick;
  logic       supv_ovf;
  logic       fire;
  logic       asn;
  logic [7:0] cfg_new;

  // Bus request decode; address phase taken only while ready
  assign take    = hsel && hready && (htrans == HTRANS_NONSEQ) && s_reg.ready;
  assign wr      = s_reg.ap_pend && s_reg.ap_write;
  assign wr_cfg  = wr && hit(s_reg.ap_addr, ADDR_CFG);
  assign wr_cnt  = wr && hit(s_reg.ap_addr, ADDR_COUNTER);
  assign wr_supv = wr && hit(s_reg.ap_addr, ADDR_SUPV);
  assign kick    = wr_supv && hwdata[SUPV_KICK_BIT];
  assign cfg_new = hwdata[7:0] & CFG_MASK;
  assign asn     = s_reg.cfg[CFG_ASN_BIT];

  // Count source; pin is synchronous, so edges come from one stored sample
  assign ext_edge = s_reg.cfg[CFG_EDGE_BIT] ? (s_reg.pin_prev && !count_pin)
                                            : (!s_reg.pin_prev && count_pin);
  assign src_tick = s_reg.cfg[CFG_SRC_BIT] ? ext_edge : 1'b1;
  // Divider ahead of the counter only when not given to the timer
  assign inc      = asn ? src_tick : dv.out_tick;

  // Supervisory timer base and its own overflow
  assign base_tick = s_reg.supv_en && (s_reg.supv_div == SUPV_BASE - WDIV_W'(1));
  assign supv_ovf  = base_tick && (s_reg.supv_cnt == CNT_MAX);
  // Divider acts as postscaler when assigned to the timer
  assign fire      = asn ? dv.out_tick : supv_ovf;

  // ----------------------------------------------------------------
  // Divider hookup
  // ----------------------------------------------------------------
  // One input mux, so the divider can never serve both units
  assign dv.in_tick = asn ? supv_ovf : src_tick;
  assign dv.clear   = s_reg.div_clr;
  assign dv.ratio   = s_reg.cfg[CFG_RATIO_LSB +: RATIO_W];

  ccwp_divider #(
    .DIV_W (8)
  ) u_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .dv      (dv.divider)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Bus, counter, timer and interrupt updates
  always_comb begin
    s_next          = s_reg;
    s_next.roll     = 1'b0;
    s_next.supv_req = 1'b0;
    s_next.div_clr  = 1'b0;
    s_next.pin_prev = count_pin;

    // Data phase: one wait cycle so read data comes from a register
    if (s_reg.ap_pend) begin
      s_next.ap_pend = 1'b0;
      s_next.ready   = 1'b1;
      s_next.rdata   = '0;
      if (!s_reg.ap_write) begin
        unique case (1'b1)
          hit(s_reg.ap_addr, ADDR_CFG):      s_next.rdata[7:0] = s_reg.cfg;
          hit(s_reg.ap_addr, ADDR_COUNTER):  s_next.rdata[7:0] = s_reg.cnt;
          hit(s_reg.ap_addr, ADDR_SUPV):     s_next.rdata[SUPV_EN_BIT] = s_reg.supv_en;
          hit(s_reg.ap_addr, ADDR_STATUS):   s_next.rdata[STS_SUPV_BIT] = s_reg.sts;
          hit(s_reg.ap_addr, ADDR_MASK):     s_next.rdata[STS_SUPV_BIT] = s_reg.msk;
          hit(s_reg.ap_addr, ADDR_SUPV_CNT): s_next.rdata[7:0] = s_reg.supv_cnt;
          default:                           s_next.rdata = '0;
        endcase
      end
    end
    if (take) begin
      s_next.ap_pend  = 1'b1;
      s_next.ap_write = hwrite;
      s_next.ap_addr  = haddr[ADDR_W-1:0];
      s_next.ready    = 1'b0;
    end

    // Configuration; reassigning the divider restarts it cleanly
    if (wr_cfg) begin
      s_next.cfg = cfg_new;
      if (cfg_new[CFG_ASN_BIT] != asn) begin
        s_next.div_clr = 1'b1;
      end
    end
    if (wr && hit(s_reg.ap_addr, ADDR_MASK)) begin
      s_next.msk = hwdata[STS_SUPV_BIT];
    end
    if (wr_supv) begin
      s_next.supv_en = hwdata[SUPV_EN_BIT];
    end

    // Counter: software load beats return-add, which takes the plain count into its sum
    if (wr_cnt) begin
      s_next.cnt = hwdata[7:0];
      if (!asn) begin
        s_next.div_clr = 1'b1;
      end
    end else if (return_add_work_to_counter) begin
      s_next.cnt = s_reg.cnt + work_value + {7'h00, inc};
    end else if (inc) begin
      s_next.cnt  = s_reg.cnt + 8'h01;
      s_next.roll = (s_reg.cnt == CNT_MAX);
    end

    // Supervisory timer; a kick restarts base, count and its divider
    if (kick) begin
      s_next.supv_cnt = '0;
      s_next.supv_div = '0;
      if (asn) begin
        s_next.div_clr = 1'b1;
      end
    end else if (s_reg.supv_en) begin
      s_next.supv_div = base_tick ? '0 : s_reg.supv_div + WDIV_W'(1);
      if (base_tick) begin
        s_next.supv_cnt = s_reg.supv_cnt + 8'h01;
      end
    end else begin
      s_next.supv_div = '0;
    end
    s_next.supv_req = fire;

    // Sticky expiry flag: a new event wins over a write-one clear
    if (wr && hit(s_reg.ap_addr, ADDR_STATUS) && hwdata[STS_SUPV_BIT]) begin
      s_next.sts = 1'b0;
    end
    if (fire) begin
      s_next.sts = 1'b1;
    end
    s_next.irq = s_next.sts && s_next.msk;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= ST_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs other than hresp straight from the state register
  assign hrdata         = s_reg.rdata;
  assign hreadyout      = s_reg.ready;
  assign hresp          = HRESP_OKAY;
  assign rollover_req   = s_reg.roll;
  assign supv_reset_req = s_reg.supv_req;
  assign irq            = s_reg.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Every check is off while reset is low; counter checks skip cycles with
  // a software load or a return-add, since a load replaces the increment and a return-add adds work_value to it
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_INT_COUNT: assert property (
    (!s_reg.cfg[CFG_SRC_BIT] && asn && !wr_cnt && !return_add_work_to_counter)
    |=> s_reg.cnt == 8'($past(s_reg.cnt) + 8'h01))
    else $error("cycle source did not advance counter");

  AST_EXT_EDGE: assert property (
    (s_reg.cfg[CFG_SRC_BIT] && asn && !ext_edge && !wr_cnt && !return_add_work_to_counter)
    |=> $stable(s_reg.cnt))
    else $error("counter moved without a pin edge");

  AST_EDGE_SEL: assert property (
    (s_reg.cfg[CFG_SRC_BIT] && s_reg.cfg[CFG_EDGE_BIT] && asn && s_reg.pin_prev && !count_pin
     && !wr_cnt && !return_add_work_to_counter)
    |=> s_reg.cnt == 8'($past(s_reg.cnt) + 8'h01))
    else $error("falling edge not counted");

  AST_WRAP: assert property (
    (inc && s_reg.cnt == CNT_MAX && !wr_cnt && !return_add_work_to_counter)
    |=> rollover_req && s_reg.cnt == 8'h00)
    else $error("wrap gave no interrupt request");

  AST_NO_PEND: assert property (
    rollover_req |=> !rollover_req)
    else $error("wrap request held past one cycle");

  AST_DIV_GATE: assert property (
    (!asn && !dv.out_tick && !wr_cnt && !return_add_work_to_counter) |=> $stable(s_reg.cnt))
    else $error("counter moved without divider tick");

  AST_ONE_USER: assert property (
    asn |-> (dv.in_tick == supv_ovf) && (inc == src_tick))
    else $error("divider shared by both units");

  AST_RET_ADD: assert property (
    (return_add_work_to_counter && !wr_cnt)
    |=> s_reg.cnt == 8'($past(s_reg.cnt) + $past(work_value) + {7'h00, $past(inc)}))
    else $error("return-add result wrong");

  AST_EXPIRE: assert property (
    (!asn && supv_ovf) |=> supv_reset_req && (irq || !s_reg.msk))
    else $error("timer expiry gave no reset request");

  AST_BUS_WAIT: assert property (
    take |=> !hreadyout ##1 hreadyout)
    else $error("bus data phase not two cycles");

  // Rising mode counts a low-to-high pin change exactly once
  AST_RISE_EDGE: assert property (
    (s_reg.cfg[CFG_SRC_BIT] && !s_reg.cfg[CFG_EDGE_BIT] && asn && !s_reg.pin_prev && count_pin
     && !wr_cnt && !return_add_work_to_counter)
    |=> s_reg.cnt == 8'($past(s_reg.cnt) + 8'h01))
    else $error("rising edge not counted");

  // A wrap pulse only ever follows a max-to-zero step
  AST_ROLL_CAUSE: assert property (
    rollover_req |-> (s_reg.cnt == 8'h00) && ($past(s_reg.cnt) == CNT_MAX))
    else $error("wrap pulse without a wrap");

  // Expiry always lands in the sticky flag, even against a clear
  AST_STS_SET: assert property (
    fire |=> s_reg.sts && supv_reset_req)
    else $error("expiry lost from status");

  // With the divider on the timer, only a divider tick may expire it
  AST_POST_GATE: assert property (
    (asn && !dv.out_tick) |=> !supv_reset_req)
    else $error("timer expired past its postscaler");

  // Each base tick steps the timer count by one
  AST_SUPV_STEP: assert property (
    (base_tick && !kick)
    |=> s_reg.supv_cnt == 8'($past(s_reg.supv_cnt) + 8'h01))
    else $error("timer count did not step");

  // Between base ticks the timer count holds
  AST_SUPV_HOLD: assert property (
    (!base_tick && !kick) |=> $stable(s_reg.supv_cnt))
    else $error("timer count moved between ticks");

  // Divider tick advances the counter when the divider sits ahead of it
  AST_PRE_TICK: assert property (
    (!asn && dv.out_tick && !wr_cnt && !return_add_work_to_counter)
    |=> s_reg.cnt == 8'($past(s_reg.cnt) + 8'h01))
    else $error("divider tick not counted");

  // Handing the divider over restarts it, so no stale count carries across
  AST_DIV_CLEAR: assert property (
    (wr_cfg && (cfg_new[CFG_ASN_BIT] != asn)) |=> dv.clear)
    else $error("divider not restarted on reassignment");

endmodule : ccwp_cycle_event_counter

/* ccwp_core_model.sv */
// Model of the count pin driver and the core's interrupt-return logic
`timescale 1ns/1ps
module ccwp_core_model (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Pulses from the block
  input  wire logic       rollover_req,
  input  wire logic       supv_reset_req,
  // Pin and core requests to the block
  output logic            count_pin,
  output logic            return_add_work_to_counter,
  output logic      [7:0] work_value
);
  // ----------------------------------------------------------------
  // Pulse bookkeeping
  // ----------------------------------------------------------------
  int roll_cnt;
  int supv_cnt;

  // Idle levels at time zero
  initial begin
    count_pin = 1'b0;
    return_add_work_to_counter = 1'b0;
    work_value = 8'h00;
  end

  // Wraps leave no flag behind, so the core side counts the pulses
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      roll_cnt <= 0;
      supv_cnt <= 0;
    end else begin
      if (rollover_req === 1'b1) roll_cnt <= roll_cnt + 1;
      if (supv_reset_req === 1'b1) supv_cnt <= supv_cnt + 1;
    end
  end

  // ----------------------------------------------------------------
  // Requests, always changed just after a rising edge
  // ----------------------------------------------------------------
  task automatic pin_set(input logic v);
    count_pin <= v;
  endtask : pin_set

  // One-cycle add; the value is scrambled after so stale data never looks valid
  task automatic add_pulse(input logic [7:0] w);
    work_value <= w;
    return_add_work_to_counter <= 1'b1;
    @(posedge hclk);
    return_add_work_to_counter <= 1'b0;
    work_value <= ~w;
  endtask : add_pulse
endmodule : ccwp_core_model

/* tb_cycle_counter_watchdog_prescaler.sv */
// Self-checking testbench for the cycle event counter block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_cycle_counter_watchdog_prescaler
  import ccwp_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd_s, a, b;
  logic        count_pin, ret_add, rollover_req, supv_reset_req, rdy_s, irq_s;
  logic [7:0]  work_value;
  int          err_total, checks, r0;
  logic [7:0]  t_ad [6] = '{ADDR_CFG, ADDR_SUPV, ADDR_STATUS, ADDR_MASK, ADDR_SUPV_CNT, 8'h18};
  logic [31:0] t_ex [6] = '{{24'h000000, CFG_RST}, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [7:0]  w_ad [5] = '{ADDR_CFG, ADDR_SUPV, ADDR_SUPV_CNT, 8'h18, 8'h1c};
  logic [31:0] w_wd [5] = '{32'hffffffff, 32'h2, 32'hff, 32'hff, 32'hff};
  logic [31:0] w_ex [5] = '{32'h3f, 32'h0, 32'h0, 32'h0, 32'h0};

  // Short time base so the supervisory chain expires within the run
  ccwp_cycle_event_counter #(.SUPV_BASE(16'h0004)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .count_pin(count_pin),
    .return_add_work_to_counter(ret_add), .work_value(work_value),
    .rollover_req(rollover_req), .supv_reset_req(supv_reset_req), .irq(irq));

  ccwp_core_model model (
    .hclk(hclk), .hresetn(hresetn), .rollover_req(rollover_req),
    .supv_reset_req(supv_reset_req), .count_pin(count_pin),
    .return_add_work_to_counter(ret_add), .work_value(work_value));

  // Clock at 200 MHz
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // Mid-cycle copies give the value seen at the next edge, free of races
  always @(negedge hclk) begin
    rdy_s = hreadyout;
    rd_s = hrdata;
    irq_s = irq;
  end

  // ----------------------------------------------------------------
  // Bus and report tasks
  // ----------------------------------------------------------------
  task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] rdv);
    hsel <= 1'b1;
    haddr <= {24'h000000, ad};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge hclk);
    while (rdy_s !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (rdy_s !== 1'b1) @(posedge hclk);
    rdv = rd_s;
  endtask : bus

  task automatic bus_write(input logic [7:0] ad, input logic [31:0] wd);
    logic [31:0] x;
    bus(1'b1, ad, wd, x);
  endtask : bus_write

  task automatic bus_read(input logic [7:0] ad, output logic [31:0] v);
    bus(1'b0, ad, 32'h0, v);
  endtask : bus_read

  task automatic end_test(input string nm);
    $display("test %s done, mismatches so far %0d", nm, err_total);
  endtask : end_test

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  // Watchdog: the whole sequence needs well under 8000 cycles
  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    $display("MISMATCH run_time exp done got hang");
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    err_total = 0;
    checks = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, read-only fields and holes where no divider shows
    for (int i = 0; i < 6; i++) begin
      bus_read(t_ad[i], a);
      `CHK("reset value", t_ex[i], a)
    end
    for (int i = 0; i < 5; i++) begin
      bus_write(w_ad[i], w_wd[i]);
      bus_read(w_ad[i], a);
      `CHK("readback", w_ex[i], a)
    end
    end_test("registers");
    // Cycle source, divider on timer: one count per cycle, 3 cycles per read
    bus_write(ADDR_CFG, 32'h08);
    bus_read(ADDR_COUNTER, a);
    bus_read(ADDR_COUNTER, b);
    `CHK("cycle count", 8'h03, 8'(b - a))
    end_test("cycle");
    // Divider on counter: a window of twice the ratio gives exactly two counts
    for (int r = 0; r < 8; r++) begin
      bus_write(ADDR_CFG, 32'(r));
      bus_read(ADDR_COUNTER, a);
      repeat ((4 << r) - 3) @(posedge hclk);
      bus_read(ADDR_COUNTER, b);
      `CHK("divided count", 8'h02, 8'(b - a))
    end
    end_test("prescale");
    // Pin source, rising then falling edge selected
    for (int e = 0; e < 2; e++) begin
      model.pin_set(1'b0);
      bus_write(ADDR_CFG, e ? 32'h38 : 32'h28);
      bus_write(ADDR_COUNTER, 32'h5a);
      bus_read(ADDR_COUNTER, a);
      `CHK("counter load", 32'h5a, a)
      model.pin_set(1'b1);
      repeat (3) @(posedge hclk);
      bus_read(ADDR_COUNTER, b);
      `CHK("rise count", e ? 8'h00 : 8'h01, 8'(b - a))
      model.pin_set(1'b0);
      repeat (3) @(posedge hclk);
      bus_read(ADDR_COUNTER, a);
      `CHK("fall count", e ? 8'h01 : 8'h00, 8'(a - b))
    end
    end_test("external");
    // Wrap gives one pulse and leaves no status or interrupt behind
    bus_write(ADDR_CFG, 32'h08);
    bus_write(ADDR_MASK, 32'h1);
    bus_write(ADDR_COUNTER, 32'hf0);
    r0 = model.roll_cnt;
    repeat (40) @(posedge hclk);
    `CHK("rollovers", 32'd1, 32'(model.roll_cnt - r0))
    bus_read(ADDR_STATUS, a);
    `CHK("status after wrap", 32'h0, a)
    `CHK("irq after wrap", 1'b0, irq_s)
    end_test("rollover");
    // Return-with-add between two reads 13 cycles apart
    bus_read(ADDR_COUNTER, a);
    repeat (4) @(posedge hclk);
    model.add_pulse(8'h30);
    repeat (5) @(posedge hclk);
    bus_read(ADDR_COUNTER, b);
    `CHK("add count", 8'h3d, 8'(b - a))
    end_test("return_add");
    // Timer alone: 256 base ticks of 4 cycles, then reset request
    bus_write(ADDR_MASK, 32'h0);
    bus_write(ADDR_CFG, 32'h00);
    bus_write(ADDR_SUPV, 32'h3);
    r0 = model.supv_cnt;
    repeat (1000) @(posedge hclk);
    `CHK("early expiry", 32'd0, 32'(model.supv_cnt - r0))
    repeat (100) @(posedge hclk);
    `CHK("expiry", 32'd1, 32'(model.supv_cnt - r0))
    bus_read(ADDR_STATUS, a);
    `CHK("status set", 32'h1, a)
    `CHK("irq masked", 1'b0, irq_s)
    bus_write(ADDR_MASK, 32'h1);
    repeat (3) @(posedge hclk);
    `CHK("irq raised", 1'b1, irq_s)
    bus_write(ADDR_SUPV, 32'h0);
    bus_write(ADDR_STATUS, 32'h1);
    repeat (3) @(posedge hclk);
    bus_read(ADDR_STATUS, a);
    `CHK("status cleared", 32'h0, a)
    `CHK("irq cleared", 1'b0, irq_s)
    // Divider after the timer doubles the chain at ratio 1:2
    bus_write(ADDR_CFG, 32'h08);
    bus_write(ADDR_SUPV, 32'h3);
    r0 = model.supv_cnt;
    repeat (1100) @(posedge hclk);
    `CHK("postscaled early", 32'd0, 32'(model.supv_cnt - r0))
    repeat (1100) @(posedge hclk);
    `CHK("postscaled expiry", 32'd1, 32'(model.supv_cnt - r0))
    end_test("supervisory");
    give_verdict();
  end
endmodule : tb_cycle_counter_watchdog_prescaler
